// [hw/cgs_pkg.sv]
package cgs_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int REG_ADDR_W = 2;
    localparam logic [1:0] ADDR_CLOCK_STOP = 2'h0;
    localparam logic [1:0] ADDR_STARTUP_OUTCOME = 2'h1;
    localparam logic [1:0] ADDR_CONFIG_SELECT = 2'h2;

    // ****************************************
    // Block clock stop fields
    // ****************************************
    localparam int BIT_ALL_LOGIC_STOP = 11;
    localparam int BIT_ACT_B_STOP = 5;
    localparam int BIT_ACT_A_STOP = 4;
    localparam int BIT_LOSS_C_STOP = 3;
    localparam int BIT_LOSS_B_STOP = 2;
    localparam int BIT_LOSS_A_STOP = 1;
    localparam logic [15:0] CLOCK_STOP_RESET = 16'h0000;
    localparam logic [15:0] CLOCK_STOP_WMASK = 16'h097F;

    // ****************************************
    // Startup outcome fields
    // ****************************************
    localparam int BIT_BIAS_TIMEOUT = 5;
    localparam int BIT_OTP_TIMEOUT = 6;
    localparam int BIT_APLL_TIMEOUT = 7;
    localparam int BIT_OSC_FALLBACK = 4;
    localparam int BIT_READY = 3;
    localparam logic [7:0] STARTUP_RESET = 8'h00;
    localparam logic [3:0] CONFIG_SELECT_RESET = 4'h4;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int BIAS_TIMEOUT_MS = 2;
    localparam int OTP_TIMEOUT_MS = 10;
    localparam int APLL_TIMEOUT_MS = 2;
    localparam int BIAS_TIMEOUT_CYC = BIAS_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int OTP_TIMEOUT_CYC = OTP_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int APLL_TIMEOUT_CYC = APLL_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int DIV_START_CYC = 64;
    localparam int TIMER_W = 20;

    // ****************************************
    // Startup sequence states
    // ****************************************
    typedef enum logic [4:0] {
        ST_WAIT_CLK = 5'b00001,
        ST_BIAS_CAL = 5'b00010,
        ST_OTP_LOAD = 5'b00100,
        ST_APLL_LOCK = 5'b01000,
        ST_DONE = 5'b10000
    } cgs_state_e;

endpackage : cgs_pkg

// [hw/cgs_clock_gate_status.sv]
// Notes on behaviour
// - Bit 11 stops all ungated internal logic clocks.
// - Bit 11 also kills register access until rst_b reset.
// - Bit 5 stops activity watch B clock.
// - Bit 4 stops activity watch A clock.
// - Bit 3 stops signal loss watch C clock.
// - Bit 2 stops signal loss watch B clock.
// - Bit 1 stops signal loss watch A clock.
// - Status bit 5 flags bias calibration timeout.
// - Status bit 6 flags configuration load timeout.
// - Status bit 7 flags PLL lock timeout.
// - Dead divider switches ring oscillator, sets bit 4.
// - Ready bit 3 set when configuration load completes.
// - Status bits 1:0 show loaded user configuration.
// - Common configuration always loaded with user one.
// - Clock stop resets zero; bits 11, 8 and 6:0 writable, others read-only.
// - Four-bit select, reset 0x4, picks user configuration.
`timescale 1ns/1ps

module cgs_clock_gate_status
    import cgs_pkg::*;
#(
    parameter int BIAS_TIMEOUT = BIAS_TIMEOUT_CYC,
    parameter int OTP_TIMEOUT = OTP_TIMEOUT_CYC,
    parameter int APLL_TIMEOUT = APLL_TIMEOUT_CYC,
    parameter int DIV_START = DIV_START_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port from the serial interface
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [REG_ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    output logic regRdValid,
    // Startup sequence handshakes
    input wire logic sysDivToggling,
    input wire logic biasCalDone,
    input wire logic otpLoadDone,
    input wire logic apllLocked,
    output logic ringOscSelect,
    output logic biasCalStart,
    output logic otpLoadStart,
    output logic otpCommonLoad,
    output logic [1:0] otpUserSelect,
    output logic apllStart,
    // Clock stop controls
    output logic allLogicClockStop,
    output logic activityWatchBClockStop,
    output logic activityWatchAClockStop,
    output logic signalLossWatchCClockStop,
    output logic signalLossWatchBClockStop,
    output logic signalLossWatchAClockStop
);

    // ****************************************
    // Parameter checks
    // ****************************************
    initial begin
        if (BIAS_TIMEOUT < 1 || OTP_TIMEOUT < 1 || APLL_TIMEOUT < 1 || DIV_START < 1 ||
            BIAS_TIMEOUT >= (1 << TIMER_W) || OTP_TIMEOUT >= (1 << TIMER_W) ||
            APLL_TIMEOUT >= (1 << TIMER_W) || DIV_START >= (1 << TIMER_W)) begin
            $error("cgs_clock_gate_status: timeout parameter out of range");
        end
    end

    localparam logic [TIMER_W-1:0] BIAS_LIM = TIMER_W'(BIAS_TIMEOUT - 1);
    localparam logic [TIMER_W-1:0] OTP_LIM = TIMER_W'(OTP_TIMEOUT - 1);
    localparam logic [TIMER_W-1:0] APLL_LIM = TIMER_W'(APLL_TIMEOUT - 1);
    localparam logic [TIMER_W-1:0] DIV_LIM = TIMER_W'(DIV_START - 1);

    logic [15:0] clockStop_r;
    logic [3:0] configSel_r;
    logic [7:0] outcome_r;
    cgs_state_e state_r;
    logic [TIMER_W-1:0] timer_r;
    logic halted;
    logic wrStop;
    logic wrSel;

    // ****************************************
    // Global stop
    // ****************************************
    // Once set, everything without its own stop bit freezes, the register port included.
    assign halted = clockStop_r[BIT_ALL_LOGIC_STOP];
    assign wrStop = regWrEn && !halted && regAddr == ADDR_CLOCK_STOP;
    assign wrSel = regWrEn && !halted && regAddr == ADDR_CONFIG_SELECT;

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            clockStop_r <= CLOCK_STOP_RESET;
        end else if (wrStop) begin
            clockStop_r <= regWrData & CLOCK_STOP_WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            configSel_r <= CONFIG_SELECT_RESET;
        end else if (wrSel) begin
            configSel_r <= regWrData[3:0];
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            regRdData <= 16'h0000;
            regRdValid <= 1'b0;
        end else if (halted) begin
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                unique case (regAddr)
                    ADDR_CLOCK_STOP: regRdData <= clockStop_r;
                    ADDR_STARTUP_OUTCOME: regRdData <= {8'h00, outcome_r};
                    ADDR_CONFIG_SELECT: regRdData <= {12'h000, configSel_r};
                    default: regRdData <= 16'h0000;
                endcase
            end
        end
    end

    // ****************************************
    // Clock stop outputs
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            allLogicClockStop <= 1'b0;
            activityWatchBClockStop <= 1'b0;
            activityWatchAClockStop <= 1'b0;
            signalLossWatchCClockStop <= 1'b0;
            signalLossWatchBClockStop <= 1'b0;
            signalLossWatchAClockStop <= 1'b0;
        end else begin
            allLogicClockStop <= clockStop_r[BIT_ALL_LOGIC_STOP];
            activityWatchBClockStop <= clockStop_r[BIT_ACT_B_STOP];
            activityWatchAClockStop <= clockStop_r[BIT_ACT_A_STOP];
            signalLossWatchCClockStop <= clockStop_r[BIT_LOSS_C_STOP];
            signalLossWatchBClockStop <= clockStop_r[BIT_LOSS_B_STOP];
            signalLossWatchAClockStop <= clockStop_r[BIT_LOSS_A_STOP];
        end
    end

    // ****************************************
    // Startup sequence
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_r <= ST_WAIT_CLK;
            timer_r <= '0;
            outcome_r <= STARTUP_RESET;
            ringOscSelect <= 1'b0;
            biasCalStart <= 1'b0;
            otpLoadStart <= 1'b0;
            otpCommonLoad <= 1'b0;
            otpUserSelect <= 2'h0;
            apllStart <= 1'b0;
        end else if (!halted) begin
            unique case (state_r)
                ST_WAIT_CLK: begin
                    if (sysDivToggling) begin
                        state_r <= ST_BIAS_CAL;
                        timer_r <= '0;
                        biasCalStart <= 1'b1;
                    end else if (timer_r == DIV_LIM) begin
                        ringOscSelect <= 1'b1;
                        outcome_r[BIT_OSC_FALLBACK] <= 1'b1;
                        state_r <= ST_BIAS_CAL;
                        timer_r <= '0;
                        biasCalStart <= 1'b1;
                    end else begin
                        timer_r <= timer_r + 1'b1;
                    end
                end
                ST_BIAS_CAL: begin
                    if (biasCalDone || timer_r == BIAS_LIM) begin
                        outcome_r[BIT_BIAS_TIMEOUT] <= !biasCalDone;
                        biasCalStart <= 1'b0;
                        state_r <= ST_OTP_LOAD;
                        timer_r <= '0;
                        otpLoadStart <= 1'b1;
                        otpCommonLoad <= 1'b1;
                        otpUserSelect <= configSel_r[1:0];
                    end else begin
                        timer_r <= timer_r + 1'b1;
                    end
                end
                ST_OTP_LOAD: begin
                    if (otpLoadDone || timer_r == OTP_LIM) begin
                        outcome_r[BIT_OTP_TIMEOUT] <= !otpLoadDone;
                        outcome_r[BIT_READY] <= otpLoadDone;
                        outcome_r[1:0] <= otpUserSelect;
                        otpLoadStart <= 1'b0;
                        otpCommonLoad <= 1'b0;
                        state_r <= ST_APLL_LOCK;
                        timer_r <= '0;
                        apllStart <= 1'b1;
                    end else begin
                        timer_r <= timer_r + 1'b1;
                    end
                end
                ST_APLL_LOCK: begin
                    if (apllLocked || timer_r == APLL_LIM) begin
                        outcome_r[BIT_APLL_TIMEOUT] <= !apllLocked;
                        state_r <= ST_DONE;
                    end else begin
                        timer_r <= timer_r + 1'b1;
                    end
                end
                ST_DONE: begin
                    state_r <= ST_DONE;
                end
            endcase
        end
    end

endmodule : cgs_clock_gate_status

// [bench/cgs_clock_gate_status_sva.sv]
`timescale 1ns/1ps
module cgs_clock_gate_status_sva
    import cgs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [REG_ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regRdValid,
    // Startup and clock stops
    input wire logic sysDivToggling,
    input wire logic ringOscSelect,
    input wire logic otpLoadStart,
    input wire logic otpCommonLoad,
    input wire logic allLogicClockStop,
    input wire logic activityWatchBClockStop,
    input wire logic activityWatchAClockStop,
    input wire logic signalLossWatchCClockStop,
    input wire logic signalLossWatchBClockStop,
    input wire logic signalLossWatchAClockStop
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence s_wr;
        regWrEn && regAddr == ADDR_CLOCK_STOP && !allLogicClockStop;
    endsequence
    AST_ALL_STOP: assert property (
        s_wr |-> ##2 allLogicClockStop == $past(regWrData[11], 2)) else $error("global stop");
    AST_ACT_STOP: assert property (
        s_wr |-> ##2 {activityWatchBClockStop, activityWatchAClockStop} ==
        $past(regWrData[5:4], 2)) else $error("activity stop");
    AST_LOSS_STOP: assert property (
        s_wr |-> ##2 {signalLossWatchCClockStop, signalLossWatchBClockStop,
        signalLossWatchAClockStop} == $past(regWrData[3:1], 2)) else $error("loss stop");
    AST_FREEZE_RD: assert property (
        allLogicClockStop |=> allLogicClockStop && !regRdValid) else $error("read after stop");
    AST_FREEZE_WR: assert property (
        allLogicClockStop |=> $stable(activityWatchBClockStop)) else $error("write after stop");
    AST_RD_VALID: assert property (
        regRdEn && !allLogicClockStop |=> regRdValid) else $error("read not answered");
    AST_COMMON: assert property (
        otpLoadStart |-> otpCommonLoad) else $error("common load missing");
    AST_FALLBACK: assert property (
        $rose(ringOscSelect) |-> !$past(sysDivToggling)) else $error("bad fallback");
endmodule : cgs_clock_gate_status_sva

bind cgs_clock_gate_status cgs_clock_gate_status_sva i_sva (
    .mclk(mclk), .rst_b(rst_b), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdValid(regRdValid), .sysDivToggling(sysDivToggling),
    .ringOscSelect(ringOscSelect), .otpLoadStart(otpLoadStart),
    .otpCommonLoad(otpCommonLoad), .allLogicClockStop(allLogicClockStop),
    .activityWatchBClockStop(activityWatchBClockStop),
    .activityWatchAClockStop(activityWatchAClockStop),
    .signalLossWatchCClockStop(signalLossWatchCClockStop),
    .signalLossWatchBClockStop(signalLossWatchBClockStop),
    .signalLossWatchAClockStop(signalLossWatchAClockStop));

// [bench/cgs_clock_gate_status_tb_top.sv]
`timescale 1ns/1ps
module cgs_clock_gate_status_tb_top;
    import cgs_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [15:0] regWrData = 16'h0000;
    logic tgl = 1'b1;
    logic bDone = 1'b1;
    logic oDone = 1'b1;
    logic pLock = 1'b1;
    logic [15:0] rdData;
    logic [15:0] rd;
    logic [15:0] d;
    logic rdVal, ring, pllGo, allStop, actB, actA, losC, losB, losA, ok;
    int errorCnt = 0;
    int nTests = 0;
    always #10 mclk = ~mclk;
    cgs_clock_gate_status #(.BIAS_TIMEOUT(20), .OTP_TIMEOUT(40), .APLL_TIMEOUT(20),
        .DIV_START(8)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(rdData), .regRdValid(rdVal),
        .sysDivToggling(tgl), .biasCalDone(bDone), .otpLoadDone(oDone), .apllLocked(pLock),
        .ringOscSelect(ring), .biasCalStart(), .otpLoadStart(), .otpCommonLoad(),
        .otpUserSelect(), .apllStart(pllGo), .allLogicClockStop(allStop),
        .activityWatchBClockStop(actB), .activityWatchAClockStop(actA),
        .signalLossWatchCClockStop(losC), .signalLossWatchBClockStop(losB),
        .signalLossWatchAClockStop(losA));
    // ****************************************
    // Access tasks
    // ****************************************
    task automatic stop_test;
        $display("checks %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            errorCnt++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [1:0] a, input logic [15:0] v);
        @(negedge mclk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = v;
        @(negedge mclk);
        regWrEn = 1'b0;
    endtask : wr
    task automatic rdReg(input logic [1:0] a);
        ok = 1'b0;
        @(negedge mclk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge mclk);
        regRdEn = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (rdVal === 1'b1 && !ok) begin
                ok = 1'b1;
                rd = rdData;
            end
            @(negedge mclk);
        end
    endtask : rdReg
    task automatic rdChk(input logic [1:0] a, input logic [15:0] exp);
        rdReg(a);
        if (!ok) begin
            errorCnt++;
            $display("unexpected read timeout at %h", a);
            stop_test();
        end
        check("read data", rd, exp);
    endtask : rdChk
    task automatic rstRun;
        @(negedge mclk);
        rst_b = 1'b0;
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
    endtask : rstRun
    task automatic waitPll;
        for (int i = 0; i < 300 && pllGo !== 1'b1; i++) @(negedge mclk);
        if (pllGo !== 1'b1) begin
            errorCnt++;
            $display("unexpected wait timeout");
            stop_test();
        end
        repeat (25) @(negedge mclk);
    endtask : waitPll
    initial begin
        rstRun();
        rdChk(ADDR_CLOCK_STOP, 16'h0000);
        rdChk(ADDR_CONFIG_SELECT, 16'h0004);
        waitPll();
        rdChk(ADDR_STARTUP_OUTCOME, 16'h0008);
        wr(ADDR_STARTUP_OUTCOME, 16'hFFFF);
        rdChk(ADDR_STARTUP_OUTCOME, 16'h0008);
        wr(2'h3, 16'hFFFF);
        rdChk(2'h3, 16'h0000);
        wr(ADDR_CLOCK_STOP, 16'hF7FF);
        rdChk(ADDR_CLOCK_STOP, 16'h017F);
        for (int i = 1; i < 6; i++) begin
            d = 16'h0001 << i;
            wr(ADDR_CLOCK_STOP, d);
            @(negedge mclk);
            check("stops", {4'h0, allStop, 5'h00, actB, actA, losC, losB, losA, 1'b0}, d);
        end
        $display("test register access done");
        tgl = 1'b0;
        bDone = 1'b0;
        oDone = 1'b0;
        pLock = 1'b0;
        rstRun();
        wr(ADDR_CONFIG_SELECT, 16'h0007);
        rdChk(ADDR_STARTUP_OUTCOME, 16'h0000);
        waitPll();
        rdChk(ADDR_STARTUP_OUTCOME, 16'h00F3);
        check("ring", {15'h0000, ring}, 16'h0001);
        $display("test startup timeouts done");
        wr(ADDR_CLOCK_STOP, 16'h0800);
        @(negedge mclk);
        check("all stop", {15'h0000, allStop}, 16'h0001);
        wr(ADDR_CLOCK_STOP, 16'h0000);
        rdReg(ADDR_CLOCK_STOP);
        check("frozen read", {15'h0000, ok}, 16'h0000);
        check("frozen stop", {15'h0000, allStop}, 16'h0001);
        $display("test global stop done");
        stop_test();
    end
endmodule : cgs_clock_gate_status_tb_top
